// ==== dual_dac_serial_load.sv ====
// serial frame capture, channel update logic and register slave
//
// Summary of operation
// - two channels, each driven from its own held 8-bit code.
// - each write is one 16-bit serial word with all control fields.
// - mode bits choose simultaneous update of both or single channel.
// - after reset both codes stay zero until a complete valid frame.
// - power-down selectable by word, with three termination choices.
// - shift register runs only while frame select is low.
// - serial data sampled on each of the first 16 falling serial clocks in a frame.
// - the word takes effect at the 16th falling edge.
// - frame select rising before 16 edges discards the frame.
`timescale 1ns/1ps

module dual_dac_serial_load
  import dual_dac_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire logic serial_data,
  input wire logic serial_clk,
  output output_state_t outputs,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // stage 0 is only read by stage 1; stage 2 is the previous clock level
  logic [2:0] sclk_q, sclk_d;
  logic [1:0] sel_q, sel_d;
  logic [1:0] sdi_q, sdi_d;

  always_comb begin
    sclk_d = {sclk_q[1:0], serial_clk};
    sel_d = {sel_q[0], frame_sel_n};
    sdi_d = {sdi_q[0], serial_data};
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      // idle levels: clock high, select high, so no false edge follows
      sclk_q <= '1;
      sel_q <= '1;
      sdi_q <= '0;
    end else begin
      sclk_q <= sclk_d;
      sel_q <= sel_d;
      sdi_q <= sdi_d;
    end
  end

  logic sclk_fall;
  logic frame_active;
  assign sclk_fall = sclk_q[2] & ~sclk_q[1];
  assign frame_active = ~sel_q[1];

  // ------------------------------------------------------------
  // serial frame and channel state
  // ------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_q, shift_d;
  logic [CNT_BITS-1:0] cnt_q, cnt_d;
  logic [CODE_BITS-1:0] hold_a_q, hold_a_d, hold_b_q, hold_b_d;
  output_state_t out_q, out_d;
  logic [7:0] frames_q, frames_d, aborts_q, aborts_d;
  logic enable_q, enable_d;
  logic [WORD_BITS-1:0] word;
  logic [1:0] chan;
  logic [1:0] mode;
  logic [CODE_BITS-1:0] code;

  always_comb begin
    shift_d = shift_q;
    cnt_d = cnt_q;
    hold_a_d = hold_a_q;
    hold_b_d = hold_b_q;
    out_d = out_q;
    frames_d = frames_q;
    aborts_d = aborts_q;
    // whole word, fields at package positions
    word = {shift_q[WORD_BITS-2:0], sdi_q[1]};
    chan = word[CHAN_HI:CHAN_LO];
    mode = word[MODE_HI:MODE_LO];
    code = word[CODE_HI:CODE_LO];
    if (!frame_active) begin
      // early rise abandons the partial word
      if (cnt_q != '0 && cnt_q < WORD_DONE) begin
        aborts_d = aborts_q + 8'h01;
      end
      cnt_d = '0;
    // shift only inside a frame; falling edges
    end else if (sclk_fall && cnt_q < WORD_DONE && enable_q) begin
      shift_d = word;
      cnt_d = cnt_q + 5'h01;
      if (cnt_q == LAST_EDGE) begin
        frames_d = frames_q + 8'h01;
        // single or simultaneous update by mode
        case (mode)
          MODE_LOAD_ONLY: begin
            if (chan == CHAN_A) hold_a_d = code;
            else hold_b_d = code;
          end
          MODE_LOAD_UPDATE: begin
            if (chan == CHAN_A) hold_a_d = code;
            else hold_b_d = code;
            out_d.code_a = (chan == CHAN_A) ? code : hold_a_q;
            out_d.code_b = (chan == CHAN_A) ? hold_b_q : code;
            out_d.powered_down = 1'b0;
          end
          MODE_WRITE_BOTH: begin
            hold_a_d = code;
            hold_b_d = code;
            out_d.code_a = code;
            out_d.code_b = code;
            out_d.powered_down = 1'b0;
          end
          MODE_POWER_DOWN: begin
            out_d.powered_down = 1'b1;
            case (chan)
              PD_SEL_1K: out_d.term = TERM_1K;
              PD_SEL_100K: out_d.term = TERM_100K;
              default: out_d.term = TERM_HIGH_Z;
            endcase
          end
          default: out_d = out_q;
        endcase
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      shift_q <= '0;
      cnt_q <= '0;
      hold_a_q <= '0;
      hold_b_q <= '0;
      out_q <= OUT_RESET;
      frames_q <= '0;
      aborts_q <= '0;
    end else begin
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      hold_a_q <= hold_a_d;
      hold_b_q <= hold_b_d;
      out_q <= out_d;
      frames_q <= frames_d;
      aborts_q <= aborts_d;
    end
  end

  // each channel driven from its own register
  assign outputs = out_q;

  // ------------------------------------------------------------
  // register slave
  // ------------------------------------------------------------
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic wr_take, rd_take;

  // address and data are taken together, one write outstanding
  assign wr_take = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_take = s_axi_arvalid & ~rvalid_q;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    enable_d = enable_q;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d = RESP_SLVERR;
      if (s_axi_awaddr == ADDR_CTRL) begin
        bresp_d = RESP_OKAY;
        if (s_axi_wstrb[0]) enable_d = s_axi_wdata[CTRL_ENABLE_BIT];
      end else if (s_axi_awaddr == ADDR_STATUS ||
                   s_axi_awaddr == ADDR_COUNT) begin
        bresp_d = RESP_OKAY;
      end
    end
    if (rd_take) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL: rdata_d = {31'h0, enable_q};
        ADDR_STATUS: rdata_d = {8'h00, cnt_q, out_q.term,
                                out_q.powered_down, out_q.code_b,
                                out_q.code_a};
        ADDR_COUNT: rdata_d = {16'h0000, aborts_q, frames_q};
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      enable_q <= CTRL_ENABLE_RESET;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      enable_q <= enable_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

// ==== dual_dac_pkg.sv ====
// constants and types shared by the dual converter serial load logic
package dual_dac_pkg;

  // ------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 8;
  localparam int CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] LAST_EDGE = 5'h0F;
  localparam logic [CNT_BITS-1:0] WORD_DONE = 5'h10;
  localparam int CHAN_HI = 15;
  localparam int CHAN_LO = 14;
  localparam int MODE_HI = 13;
  localparam int MODE_LO = 12;
  localparam int CODE_HI = 11;
  localparam int CODE_LO = 4;

  // mode field encodings
  localparam logic [1:0] MODE_LOAD_ONLY = 2'h0;
  localparam logic [1:0] MODE_LOAD_UPDATE = 2'h1;
  localparam logic [1:0] MODE_WRITE_BOTH = 2'h2;
  localparam logic [1:0] MODE_POWER_DOWN = 2'h3;
  localparam logic [1:0] CHAN_A = 2'h0;

  // channel field of a power-down word picks the termination
  localparam logic [1:0] PD_SEL_1K = 2'h0;
  localparam logic [1:0] PD_SEL_100K = 2'h1;

  typedef enum logic [1:0] {
    TERM_1K = 2'h0,
    TERM_100K = 2'h1,
    TERM_HIGH_Z = 2'h2
  } term_t;

  typedef struct packed {
    logic [CODE_BITS-1:0] code_a;
    logic [CODE_BITS-1:0] code_b;
    logic powered_down;
    term_t term;
  } output_state_t;

  localparam output_state_t OUT_RESET = '{
    code_a: 8'h00, code_b: 8'h00, powered_down: 1'b0, term: TERM_1K};

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== dual_dac_serial_load_checker.sv ====
// assertion checker for the dual converter serial load block
`timescale 1ns/1ps
module dual_dac_serial_load_checker
  import dual_dac_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_sel_n,
  input wire output_state_t outputs,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_reset_zero: assert property ($past(srst) |-> outputs == OUT_RESET)
    else $error("outputs not zero after reset");
  a_idle_holds: assert property
    (frame_sel_n [*6] |=> $stable(outputs))
    else $error("outputs moved outside a frame");
  a_commit_in_frame: assert property ($changed(outputs) |->
    !frame_sel_n && !$past(frame_sel_n, 8))
    else $error("outputs changed without a long frame");
  a_pd_keeps_codes: assert property ($rose(outputs.powered_down) |->
    $stable(outputs.code_a) && $stable(outputs.code_b))
    else $error("power-down altered the codes");
  a_write_answer: assert property
    (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response late");
  a_write_drop: assert property
    (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held too long");
  a_read_answer: assert property
    (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read response late");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_write_stands: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before ready");
  a_read_stands: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read response dropped before ready");
  cover property ($rose(outputs.powered_down));
  cover property ($changed(outputs.code_a));
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind dual_dac_serial_load dual_dac_serial_load_checker i_chk (.*);

// ==== serial_host_model.sv ====
// host model driving the three-wire link of the block
`timescale 1ns/1ps
module serial_host_model (
  output logic frame_sel_n,
  output logic serial_clk,
  output logic serial_data
);
  initial begin
    frame_sel_n = 1'b1;
    serial_clk = 1'b1;
    serial_data = 1'b0;
  end
  // msb first, set up half a period before the fall
  task automatic send(input logic [15:0] w, input int n);
    #3;
    frame_sel_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_data = w[15-i];
      #80 serial_clk = 1'b0;
      #80 serial_clk = 1'b1;
    end
    // release select; the data line shows no stale bit
    #80 frame_sel_n = 1'b1;
    serial_data = ~serial_data;
    #160;
  endtask
endmodule

// ==== dual_dac_serial_load_bench.sv ====
// self-checking bench for the dual converter serial load block
`timescale 1ns/1ps
module dual_dac_serial_load_bench;
  import dual_dac_pkg::*;
  logic clock = 0, srst = 1;
  logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hF;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, fs_n, sck, sdi;
  logic [1:0] bresp, rresp, r;
  output_state_t outputs;
  int failures = 0, checked = 0, cyc = 0;
  always #4 clock = ~clock;
  serial_host_model i_serial_host_model (.frame_sel_n(fs_n),
    .serial_clk(sck), .serial_data(sdi));
  dual_dac_serial_load i_dual_dac_serial_load (.clock(clock), .srst(srst),
    .frame_sel_n(fs_n), .serial_data(sdi), .serial_clk(sck),
    .outputs(outputs), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask
  function automatic logic [15:0] w(logic [1:0] c, logic [1:0] m,
    logic [7:0] v);
    return {c, m, v, 4'h0};
  endfunction
  function automatic logic [31:0] st(logic [7:0] a, logic [7:0] b,
    logic p, term_t t);
    output_state_t s;
    s = '{code_a: a, code_b: b, powered_down: p, term: t};
    return 32'(s);
  endfunction
  task automatic frame(logic [1:0] c, logic [1:0] m, logic [7:0] v, int n);
    i_serial_host_model.send(w(c, m, v), n);
  endtask
  // ------
  // tests
  // ------
  task automatic t_reset;
    chk(32'(outputs), 32'(OUT_RESET));
    rd(ADDR_CTRL);
    chk(d, 32'h1);
    rd(4'hC);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    wr(ADDR_STATUS, 32'hFFFFFFFF);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    wr(4'hC, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(32'(outputs), 32'(OUT_RESET));
    $display("reset test done");
  endtask
  task automatic t_load;
    frame(CHAN_A, MODE_WRITE_BOTH, 8'h5A, 16);
    chk(32'(outputs), st(8'h5A, 8'h5A, 0, TERM_1K));
    frame(2'h1, MODE_LOAD_ONLY, 8'h33, 16);
    chk(32'(outputs), st(8'h5A, 8'h5A, 0, TERM_1K));
    frame(CHAN_A, MODE_LOAD_UPDATE, 8'hC3, 16);
    chk(32'(outputs), st(8'hC3, 8'h33, 0, TERM_1K));
    frame(CHAN_A, MODE_WRITE_BOTH, 8'hFF, 15);
    chk(32'(outputs), st(8'hC3, 8'h33, 0, TERM_1K));
    rd(ADDR_COUNT);
    chk(d & 32'hFFFF, 32'h0103);
    $display("load test done");
  endtask
  task automatic t_power;
    term_t t;
    for (int c = 0; c < 4; c++) begin
      t = (c == 0) ? TERM_1K : (c == 1) ? TERM_100K : TERM_HIGH_Z;
      frame(2'(c), MODE_POWER_DOWN, 8'h00, 16);
      chk(32'(outputs), st(8'hC3, 8'h33, 1, t));
    end
    rd(ADDR_STATUS);
    chk(d, 32'h0005_33C3);
    frame(CHAN_A, MODE_WRITE_BOTH, 8'h81, 16);
    chk(32'(outputs), st(8'h81, 8'h81, 0, TERM_HIGH_Z));
    $display("power test done");
  endtask
  task automatic t_enable;
    wr(ADDR_CTRL, 32'h0);
    frame(CHAN_A, MODE_WRITE_BOTH, 8'h11, 16);
    chk(32'(outputs), st(8'h81, 8'h81, 0, TERM_HIGH_Z));
    wr(ADDR_CTRL, 32'h1);
    frame(CHAN_A, MODE_WRITE_BOTH, 8'h22, 16);
    chk(32'(outputs), st(8'h22, 8'h22, 0, TERM_HIGH_Z));
    rd(ADDR_COUNT);
    chk(d & 32'hFFFF, 32'h0109);
    $display("enable test done");
  endtask
  initial begin
    repeat (10) @(posedge clock);
    srst <= 0;
    repeat (3) @(posedge clock);
    t_reset();
    t_load();
    t_power();
    t_enable();
    end_of_test();
  end
endmodule
